// file: ixo_pkg.sv
// Shared constants, encodings and types of the indexed offset executor
package ixo_pkg;

  // Data space and operand widths
  localparam int unsigned ADDR_W    = 12;     // Data space address width
  localparam int unsigned DATA_W    = 8;      // Data byte width
  localparam int unsigned INSTR_W   = 16;     // One program word
  localparam int unsigned BANK_W    = 4;      // Bank select width

  // Opcode fields
  localparam int unsigned OP_HI     = 15;     // Top bit of opcode field
  localparam int unsigned A_BIT     = 8;      // Bank select flag position
  localparam int unsigned D_BIT     = 9;      // Destination bit position
  localparam int unsigned B_LSB     = 9;      // Bit number field, low bit
  localparam int unsigned B_MSB     = 11;     // Bit number field, high bit

  // Opcode match patterns, compared above the bank select flag
  localparam logic [5:0] OPC_ADD    = 6'h09;  // 0010 01 on bits 15:10
  localparam logic [3:0] OPC_BSET   = 4'h8;   // 1000 on bits 15:12
  localparam logic [6:0] OPC_FILL   = 7'h34;  // 0110 100 on bits 15:9

  // Addressing constants
  localparam logic [7:0] IDX_LIMIT  = 8'h5F;  // Highest indexed operand
  localparam logic [3:0] SFR_BANK   = 4'hF;   // Upper access half bank
  localparam logic [3:0] LOW_BANK   = 4'h0;   // Lower access half bank
  localparam logic [7:0] FILL_VAL   = 8'hFF;  // Fill pattern
  localparam logic [3:0] NIB_MASK   = 4'hF;   // Nibble mask

  // Reset values
  localparam logic [7:0] W_RST      = 8'h00;  // Working register reset
  localparam logic       XEN_RST    = 1'b0;   // Extension off at reset

  // Status flags touched by the add
  typedef struct packed {
    logic n;   // Negative
    logic ov;  // Overflow
    logic z;   // Zero
    logic dc;  // Digit carry
    logic c;   // Carry
  } ixo_status_t;

  localparam ixo_status_t STATUS_RST = '{default: 1'b0};

  // Observable data space write
  typedef struct packed {
    logic              we;    // Write strobe
    logic [ADDR_W-1:0] addr;  // Byte address
    logic [DATA_W-1:0] data;  // Byte written
  } ixo_mem_wr_t;

  localparam ixo_mem_wr_t MEM_WR_RST = '{default: 1'b0};

  // Instruction kinds
  typedef enum logic [1:0] {
    IK_NONE,
    IK_ADD,
    IK_BSET,
    IK_FILL
  } ixo_kind_t;

endpackage : ixo_pkg

// file: ixo_mem.sv
// Single port data byte memory with registered read data
module ixo_mem #(
  parameter int unsigned AW = ixo_pkg::ADDR_W,  // Address width
  parameter int unsigned DW = ixo_pkg::DATA_W   // Data width
) (
  input  wire logic          clk_i,    // Core clock
  input  wire logic          ce_i,     // Clock enable
  input  wire logic          we_i,     // Write strobe
  input  wire logic [AW-1:0] addr_i,   // Byte address
  input  wire logic [DW-1:0] wdata_i,  // Write data
  output logic      [DW-1:0] rdata_o   // Registered read data
);

  // Storage array, no reset so it maps to RAM
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // Read first: write into the array, read old contents into the register
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_r[addr_i] <= wdata_i;
      end
      rdata_o <= mem_r[addr_i];
    end
  end

endmodule : ixo_mem

// file: ixo_exec.sv
// Indexed literal offset decoder and executor for three byte/bit instructions
// Function
// RQ1: Small access operands offset from frame pointer
// RQ2: Indexed only when bank flag zero, operand<=5Fh
// RQ3: Add-indexed adds working register to indexed byte
// RQ4: Indexed offsets limited to 0 through 95
// RQ5: Destination bit selects working register or memory
// RQ6: Add updates N, OV, C, DC, Z
// RQ7: Bit-set-indexed sets bit b, flags unchanged
// RQ8: Fill-indexed writes FFh, flags unchanged
// RQ9: Extension enable defaults off; one enables
// RQ10: Zero frame pointer gives original access mapping
// RQ11: One word, one cycle of four phases
module ixo_exec #(
  parameter int unsigned AW = ixo_pkg::ADDR_W  // Data space address width
) (
  input  wire logic                         clk_i,       // Core clock
  input  wire logic                         nrst_i,      // Async reset, low
  input  wire logic                         ce_i,        // Clock enable
  input  wire logic                         ext_cfg_i,   // Programmed config
  input  wire logic                         instr_vld_i, // Instruction offered
  input  wire logic [ixo_pkg::INSTR_W-1:0]  instr_i,     // Program word
  input  wire logic [AW-1:0]                sfp_i,       // Frame pointer
  input  wire logic [ixo_pkg::BANK_W-1:0]   bank_i,      // Bank select value
  input  wire logic                         ld_we_i,     // Loader byte write
  input  wire logic [AW-1:0]                ld_addr_i,   // Loader address
  input  wire logic [ixo_pkg::DATA_W-1:0]   ld_data_i,   // Loader data
  input  wire logic                         w_ld_i,      // Load working reg
  input  wire logic [ixo_pkg::DATA_W-1:0]   w_ld_data_i, // Working reg value
  output logic                              ready_o,     // In decode phase
  output logic                              done_o,      // Instruction retired
  output logic                              indexed_o,   // Last used offset
  output logic                              ext_en_o,    // Extension active
  output logic [ixo_pkg::DATA_W-1:0]        w_o,         // Working register
  output ixo_pkg::ixo_status_t              status_o,    // Status flags
  output ixo_pkg::ixo_mem_wr_t              mem_wr_o     // Data space write
);

  // Four phases make one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROC,
    PH_WRITE
  } ixo_phase_t;

  // Effective address: offset from frame pointer, bank, or access half
  function automatic logic [AW-1:0] ixo_ea(
    input logic                       idx,
    input logic                       a,
    input logic [7:0]                 f,
    input logic [AW-1:0]              fp,
    input logic [ixo_pkg::BANK_W-1:0] bank
  );
    logic [AW-1:0] ea;
    ea = '0;
    if (idx) begin
      ea = fp + AW'(f);                                      // [RQ1] [RQ10]
    end else if (a) begin
      ea = AW'({bank, f});
    end else if (f > ixo_pkg::IDX_LIMIT) begin
      ea = AW'({ixo_pkg::SFR_BANK, f});
    end else begin
      ea = AW'({ixo_pkg::LOW_BANK, f});                      // [RQ10]
    end
    return ea;
  endfunction : ixo_ea

  // Phase and latched instruction state
  ixo_phase_t             phase_r, phase_nxt;
  ixo_pkg::ixo_kind_t     kind_r;     // Decoded kind
  logic                   dest_r;     // Destination bit
  logic [2:0]             bnum_r;     // Bit number
  logic [AW-1:0]          addr_r;     // Resolved address
  logic [7:0]             res_r;      // Result of process phase
  ixo_pkg::ixo_status_t   flags_r;    // Flags from process phase
  logic                   xen_r;      // Captured extension enable
  logic                   xcap_r;     // Capture done after reset

  // Decoder wires, looked at only in the decode phase
  wire [ixo_pkg::INSTR_W-1:0] iw = instr_i;
  wire        a_bit  = iw[ixo_pkg::A_BIT];
  wire [7:0]  f_fld  = iw[7:0];
  wire        is_add = iw[ixo_pkg::OP_HI -: 6] == ixo_pkg::OPC_ADD;  // [RQ3]
  wire        is_bs  = iw[ixo_pkg::OP_HI -: 4] == ixo_pkg::OPC_BSET; // [RQ7]
  wire        is_fl  = iw[ixo_pkg::OP_HI -: 7] == ixo_pkg::OPC_FILL; // [RQ8]
  // Live config until the capture edge, so a word taken there sees it too
  wire        xen_now = xcap_r ? xen_r : ext_cfg_i;                // [RQ9]
  // Offset mode needs the extension, a clear bank flag, operand 0..95
  wire        use_idx = xen_now && !a_bit &&
                        (f_fld <= ixo_pkg::IDX_LIMIT);   // [RQ2] [RQ4] [RQ9]
  wire [AW-1:0] ea   = ixo_ea(use_idx, a_bit, f_fld, sfp_i, bank_i);
  wire        take   = (phase_r == PH_DECODE) && instr_vld_i;

  // Kind from opcode
  wire ixo_pkg::ixo_kind_t kind_dec = is_add ? ixo_pkg::IK_ADD  :
                                      is_bs  ? ixo_pkg::IK_BSET :
                                      is_fl  ? ixo_pkg::IK_FILL :
                                               ixo_pkg::IK_NONE;

  // Memory port: loader owns it while no instruction is in flight
  logic [7:0]  rdata;
  wire  busy     = phase_r != PH_DECODE;
  wire  core_we  = (phase_r == PH_WRITE) && (kind_r != ixo_pkg::IK_NONE) &&
                   ((kind_r != ixo_pkg::IK_ADD) || dest_r);          // [RQ5]
  wire  ld_go    = !busy && !instr_vld_i && ld_we_i;
  wire  mem_we   = core_we || ld_go;
  wire [AW-1:0] mem_addr = busy ? addr_r : ld_addr_i;
  wire [7:0]    mem_wdat = busy ? res_r : ld_data_i;

  // Add datapath with nibble and sign carries
  wire [8:0] sum9  = {1'b0, w_o} + {1'b0, rdata};                    // [RQ3]
  wire [4:0] nib5  = {1'b0, w_o[3:0] & ixo_pkg::NIB_MASK} +
                     {1'b0, rdata[3:0]};
  wire [7:0] sum8  = sum9[7:0];
  wire       ov    = (w_o[7] == rdata[7]) && (sum8[7] != w_o[7]);
  wire ixo_pkg::ixo_status_t add_flags = '{n:  sum8[7],
                                           ov: ov,
                                           z:  sum8 == 8'h00,
                                           dc: nib5[4],
                                           c:  sum9[8]};             // [RQ6]
  wire [7:0] bmask = 8'h01 << bnum_r;

  // Process phase result selection
  wire [7:0] res_nxt = (kind_r == ixo_pkg::IK_ADD)  ? sum8 :
                       (kind_r == ixo_pkg::IK_BSET) ? (rdata | bmask) :
                       (kind_r == ixo_pkg::IK_FILL) ? ixo_pkg::FILL_VAL :
                                                      rdata;   // [RQ7] [RQ8]

  // Phase sequencing, one instruction per four clocks
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      PH_DECODE: if (instr_vld_i) phase_nxt = PH_READ;             // [RQ11]
      PH_READ:   phase_nxt = PH_PROC;
      PH_PROC:   phase_nxt = PH_WRITE;
      PH_WRITE:  phase_nxt = PH_DECODE;
    endcase
  end

  // Data byte storage
  ixo_mem #(
    .AW (AW),
    .DW (ixo_pkg::DATA_W)
  ) u_mem (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdat),
    .rdata_o (rdata)
  );

  // Config capture: a clocked load after release, never a reset load
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xen_r  <= ixo_pkg::XEN_RST;                                    // [RQ9]
      xcap_r <= 1'b0;
    end else if (ce_i && !xcap_r) begin
      xen_r  <= ext_cfg_i;                                           // [RQ9]
      xcap_r <= 1'b1;
    end
  end

  // Phase register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_r <= PH_DECODE;
    end else if (ce_i) begin
      phase_r <= phase_nxt;
    end
  end

  // Decode phase latches kind, fields and resolved address
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      kind_r    <= ixo_pkg::IK_NONE;
      dest_r    <= 1'b0;
      bnum_r    <= 3'h0;
      addr_r    <= '0;
      indexed_o <= 1'b0;
    end else if (ce_i && take) begin
      kind_r    <= kind_dec;
      dest_r    <= iw[ixo_pkg::D_BIT];                               // [RQ5]
      bnum_r    <= iw[ixo_pkg::B_MSB:ixo_pkg::B_LSB];                // [RQ7]
      addr_r    <= ea;                                               // [RQ1]
      indexed_o <= use_idx && (kind_dec != ixo_pkg::IK_NONE);
    end
  end

  // Process phase holds result and flags for the write phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_r   <= 8'h00;
      flags_r <= ixo_pkg::STATUS_RST;
    end else if (ce_i && phase_r == PH_PROC) begin
      res_r   <= res_nxt;
      flags_r <= add_flags;
    end
  end

  // Write phase: working register and flags; loader may preset W when idle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_o      <= ixo_pkg::W_RST;
      status_o <= ixo_pkg::STATUS_RST;
    end else if (ce_i) begin
      if (phase_r == PH_WRITE && kind_r == ixo_pkg::IK_ADD) begin
        status_o <= flags_r;                                         // [RQ6]
        if (!dest_r) begin
          w_o <= res_r;                                              // [RQ5]
        end
      end else if (!busy && !instr_vld_i && w_ld_i) begin
        w_o <= w_ld_data_i;
      end
    end
  end

  // Registered handshake and observation outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_o  <= 1'b0;
      done_o   <= 1'b0;
      ext_en_o <= 1'b0;
      mem_wr_o <= ixo_pkg::MEM_WR_RST;
    end else if (ce_i) begin
      // Ready mirrors the phase that the next clock will be in
      ready_o  <= phase_nxt == PH_DECODE;
      done_o   <= phase_r == PH_WRITE;                               // [RQ11]
      ext_en_o <= xen_now;
      mem_wr_o <= '{we: core_we, addr: addr_r, data: res_r};
    end
  end

endmodule : ixo_exec

// file: ixo_exec_assertions.sv
// Port-level checks of the indexed offset executor
module ixo_exec_assertions #(
  parameter int unsigned AW = ixo_pkg::ADDR_W  // Address width
) (
  input wire logic                        clk_i,
  input wire logic                        nrst_i,
  input wire logic                        ce_i,
  input wire logic                        ext_cfg_i,
  input wire logic                        instr_vld_i,
  input wire logic [ixo_pkg::INSTR_W-1:0] instr_i,
  input wire logic [AW-1:0]               sfp_i,
  input wire logic [ixo_pkg::BANK_W-1:0]  bank_i,
  input wire logic                        ready_o,
  input wire logic                        done_o,
  input wire logic                        indexed_o,
  input wire logic                        ext_en_o,
  input wire ixo_pkg::ixo_status_t        status_o,
  input wire ixo_pkg::ixo_mem_wr_t        mem_wr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // First edge after reset: decode phase although ready is still low
  logic               fresh_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fresh_r <= 1'b1;
    end else if (ce_i) begin
      fresh_r <= 1'b0;
    end
  end
  // Word accepted on this edge
  wire logic          take_w = ce_i && (ready_o || fresh_r) && instr_vld_i;
  wire logic [7:0]    f_w    = instr_i[7:0];
  // Config is still live at the capture edge
  wire logic          xen_w  = fresh_r ? ext_cfg_i : ext_en_o;
  // Offset form only for access bank operands at or below the boundary
  wire logic          idx_w  = xen_w && !instr_i[8] && f_w <= 8'h5F;
  wire logic [AW-1:0] lit_w  = instr_i[8] ? AW'({bank_i, f_w})
                             : AW'({((f_w > 8'h5F) ? 4'hF : 4'h0), f_w});
  wire logic [AW-1:0] ea_w   = idx_w ? AW'(sfp_i + AW'(f_w)) : lit_w;
  logic [15:0]        op_r;   // Word in flight
  logic [AW-1:0]      ea_r;   // Its expected address
  logic               idx_r;  // Its expected form
  // Capture at take; frame pointer may move later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_r  <= '0;
      ea_r  <= '0;
      idx_r <= 1'b0;
    end else if (take_w) begin
      op_r  <= instr_i;
      ea_r  <= ea_w;
      idx_r <= idx_w;
    end
  end
  wire logic add_w  = op_r[15:10] == ixo_pkg::OPC_ADD;
  wire logic bset_w = op_r[15:12] == ixo_pkg::OPC_BSET;
  wire logic fill_w = op_r[15:9] == ixo_pkg::OPC_FILL;
  chk_done_latency: assert property (
    take_w ##1 ce_i[*3] |=> done_o)
    else $error("done missing four edges after take");
  chk_busy_window: assert property (
    take_w |=> !ready_o[*3] ##1 ready_o)
    else $error("ready wrong during execution");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_write_addr: assert property (
    done_o && mem_wr_o.we |-> mem_wr_o.addr == ea_r)
    else $error("write address wrong");
  chk_index_flag: assert property (
    done_o && (add_w || bset_w || fill_w) |-> indexed_o == idx_r)
    else $error("indexed flag wrong");
  chk_fill_value: assert property (
    done_o && fill_w |-> mem_wr_o.we && mem_wr_o.data == 8'hFF)
    else $error("fill byte wrong");
  chk_bset_bit: assert property (
    done_o && bset_w |-> mem_wr_o.we && mem_wr_o.data[op_r[11:9]])
    else $error("bit not set");
  chk_add_dest: assert property (
    done_o && add_w |-> mem_wr_o.we == op_r[9])
    else $error("add destination wrong");
  chk_flags_kept: assert property (
    take_w && instr_i[15:10] != 6'h09 |=> $stable(status_o)[*4])
    else $error("flags moved");
  chk_ext_frozen: assert property (ready_o |=> $stable(ext_en_o))
    else $error("extension enable changed");
endmodule : ixo_exec_assertions

bind ixo_exec ixo_exec_assertions #(.AW(AW)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .ext_cfg_i(ext_cfg_i),
  .instr_vld_i(instr_vld_i),
  .instr_i(instr_i), .sfp_i(sfp_i), .bank_i(bank_i), .ready_o(ready_o),
  .done_o(done_o), .indexed_o(indexed_o), .ext_en_o(ext_en_o),
  .status_o(status_o), .mem_wr_o(mem_wr_o));

// file: tb_ixo_exec.sv
// Self-checking bench for the indexed offset executor
module tb_ixo_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, nrst_i, cfg, vld, ld_we, w_ld, rdy, done, idx, xen;
  logic [15:0] op;
  logic [11:0] sfp, la;
  logic [7:0]  ld, wd, w;
  logic [3:0]  bank;
  ixo_pkg::ixo_status_t st;
  ixo_pkg::ixo_mem_wr_t mw;
  int          num_errors = 0, n_compared = 0;
  // 250 MHz core clock
  initial forever #2 clk_i = ~clk_i;
  ixo_exec dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .ext_cfg_i(cfg),
    .instr_vld_i(vld), .instr_i(op), .sfp_i(sfp), .bank_i(bank),
    .ld_we_i(ld_we), .ld_addr_i(la), .ld_data_i(ld), .w_ld_i(w_ld),
    .w_ld_data_i(wd), .ready_o(rdy), .done_o(done), .indexed_o(idx),
    .ext_en_o(xen), .w_o(w), .status_o(st), .mem_wr_o(mw));
  // Verdict and end of run
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Compare, widths zero extended; wide enough for the largest bundle
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for idle or retire, sampled mid-cycle
  task automatic wait_for(input bit want_done);
    int k;
    k = 0;
    while ((want_done ? done : rdy) !== 1'b1) begin
      @(negedge clk_i);
      k++;
      if (k > 20) begin
        num_errors++;
        wrap_up();
      end
    end
  endtask : wait_for
  // Offer one word; held one cycle since ready guarantees the take
  task automatic run(input logic [15:0] o);
    wait_for(0);
    op = o;
    vld = 1;
    @(negedge clk_i);
    vld = 0;
    wait_for(1);
  endtask : run
  // Preset a byte, or the working register when isw
  task automatic poke(input logic [11:0] a, input logic [7:0] d, input bit isw);
    wait_for(0);
    la = a;
    ld = d;
    wd = d;
    ld_we = !isw;
    w_ld = isw;
    @(negedge clk_i);
    ld_we = 0;
    w_ld = 0;
  endtask : poke
  // Reset for five cycles with a given config
  task automatic rst(input logic c);
    nrst_i = 0;
    cfg = c;
    repeat (5) @(negedge clk_i);
    nrst_i = 1;
  endtask : rst
  // Main sequence
  initial begin
    {vld, ld_we, w_ld, op, la, ld, wd, bank} = '0;
    sfp = 12'hA00;
    rst(0);
    run(16'h6810);
    chk({xen, idx, mw}, {2'b00, 1'b1, 12'h010, 8'hFF});
    rst(1);
    poke(12'h000, 8'h17, 1);
    cfg = 0; // Captured already; later changes must be ignored
    poke(12'hA2C, 8'h20, 0);
    run(16'h242C);
    chk({xen, idx, mw.we, w, st}, {3'b110, 8'h37, 5'h00});
    run(16'h262C);
    chk({mw, w}, {1'b1, 12'hA2C, 8'h57, 8'h37});
    poke(12'h000, 8'h80, 1);
    poke(12'hA00, 8'h80, 0);
    run(16'h2400);
    chk({w, st}, {8'h00, 5'b01101});
    poke(12'hA0A, 8'h55, 0);
    run(16'h8E0A);
    chk({mw, st}, {1'b1, 12'hA0A, 8'hD5, 5'b01101});
    poke(12'hA05, 8'h00, 0);
    for (int b = 0; b < 8; b++) begin
      run({4'h8, 3'(b), 9'h005});
      chk(mw, {1'b1, 12'hA05, 8'((1 << (b + 1)) - 1)});
    end
    run(16'h685F);
    chk({idx, mw, st}, {2'b11, 12'hA5F, 8'hFF, 5'b01101});
    run(16'h6860);
    chk({idx, mw}, {2'b01, 12'hF60, 8'hFF});
    bank = 4'h3;
    run(16'h6910);
    chk({idx, mw}, {2'b01, 12'h310, 8'hFF});
    poke(12'h000, 8'h8F, 1);
    poke(12'hA01, 8'h01, 0);
    run(16'h2401);
    chk({w, st}, {8'h90, 5'b10010});
    sfp = 12'h000;
    run(16'h6820);
    chk({idx, mw}, {2'b11, 12'h020, 8'hFF});
    run(16'h0010);
    chk({mw.we, w, st}, {1'b0, 8'h90, 5'b10010});
    wrap_up();
  end
endmodule : tb_ixo_exec
